// *** csd_cycle_timer.sv ***
// Access-cycle timer: wait cycles, external waits, read recovery
`timescale 1ns/10ps
`default_nettype none
module csd_cycle_timer (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Decoder side
   csd_tmr_if.tmr tif
);
   csd_pkg::csd_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic ext_q, ext_d;
   logic rd_q, rd_d;
   logic [3:0] rec_q, rec_d;
   logic done;

   // Next state of the sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      ext_d = ext_q;
      rd_d = rd_q;
      rec_d = rec_q;
      done = 1'b0;
      case (state_q)
         csd_pkg::ST_IDLE: if (tif.start) begin
            state_d = csd_pkg::ST_ACCESS;
            rd_d = tif.is_read;
            ext_d = (tif.wait_code == csd_pkg::WAIT_EXT);
            if (tif.wait_code == csd_pkg::WAIT_EXT) begin
               cnt_d = csd_pkg::WAIT_EXT_BASE;
            end else if (tif.wait_code <= csd_pkg::WAIT_MAX) begin
               cnt_d = tif.wait_code;
            end else begin
               cnt_d = 4'h0;
            end
            if (tif.rec_code == csd_pkg::REC_TWO) begin
               rec_d = 4'h2;
            end else if (tif.rec_code == csd_pkg::REC_ONE) begin
               rec_d = 4'h1;
            end else begin
               rec_d = 4'h0;
            end
         end
         csd_pkg::ST_ACCESS: if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
         end else if (ext_q && tif.ext_wait) begin
            cnt_d = 4'h0;
         end else begin
            done = 1'b1;
            if (rd_q && rec_q != 4'h0) begin
               state_d = csd_pkg::ST_RECOVER;
               cnt_d = rec_q - 4'h1;
            end else begin
               state_d = csd_pkg::ST_IDLE;
            end
         end
         csd_pkg::ST_RECOVER: if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
         end else begin
            state_d = csd_pkg::ST_IDLE;
         end
         default: state_d = csd_pkg::ST_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q <= csd_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         ext_q <= 1'b0;
         rd_q <= 1'b0;
         rec_q <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ext_q <= ext_d;
         rd_q <= rd_d;
         rec_q <= rec_d;
      end
   end

   assign tif.active = (state_q != csd_pkg::ST_IDLE);
   assign tif.done = done;
   assign tif.recover = (state_q == csd_pkg::ST_RECOVER);
endmodule
`default_nettype wire

// *** csd_mem_model.sv ***
// External memory model answering on the chip selects
`timescale 1ns/10ps
`default_nettype none
module csd_mem_model (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Strobes from the decoder
   input wire logic [3:0] select_output_n_i,
   // Wait requests to hold per access
   input wire logic [3:0] stall_i,
   // Wait request to the decoder
   output logic ext_wait_o
);
   logic [4:0] low_cnt_q = 5'h0;
   wire any_low = select_output_n_i !== 4'hf;
   // Count strobe cycles; restarts whenever all selects are high
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !any_low) low_cnt_q <= 5'h0;
      else low_cnt_q <= low_cnt_q + 5'h1;
   end
   // Slow device asks for waits from the second strobe cycle on
   assign ext_wait_o = any_low && low_cnt_q >= 5'h1 && low_cnt_q < 5'(stall_i) + 5'h1;
endmodule
`default_nettype wire

// *** csd_pkg.sv ***
// Shared constants and types for the chip-select space decoder
package csd_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_BM [4] = '{32'hffffe400, 32'hffffe404,
                                          32'hffffe408, 32'hffffe40c};
   localparam logic [31:0] ADDR_CTL [3] = '{32'hffffe480, 32'hffffe484,
                                           32'hffffe488};
   localparam logic [31:0] ADDR_STAT = 32'hffffe490;
   // Values after reset, then the control write mask
   localparam logic [31:0] BM_RST = 32'h000001ff;
   localparam logic [31:0] CTL_RST [3] = '{32'h00050005, 32'h00050805,
                                          32'h00000805};
   localparam logic [31:0] CTL_WMASK = 32'h0bdf0bdf;
   // Field positions inside one 16-bit half of a control register; BASE_LSB is in the base/mask register
   localparam int HALF = 16;
   localparam int WAIT_LSB = 0;
   localparam int WIDTH_BIT = 4;
   localparam int WAVE_LSB = 6;
   localparam int REC_LSB = 8;
   localparam int EN_BIT = 11;
   localparam int BASE_LSB = 16;
   // Field codes
   localparam logic [3:0] WAIT_MAX = 4'h7;
   localparam logic [3:0] WAIT_EXT = 4'hf;
   localparam logic [3:0] WAIT_EXT_BASE = 4'h1;
   localparam logic [1:0] REC_TWO = 2'h0;
   localparam logic [1:0] REC_ONE = 2'h1;
   // Excluded address range, kept as printed
   localparam logic [31:0] EXCL_LO = 32'hffff8000;
   localparam logic [31:0] EXCL_HI = 32'h1fffbfff;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Access sequencer states, Gray along idle-access-recover
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCESS = 2'b01,
      ST_RECOVER = 2'b11
   } csd_state_e;
endpackage

// *** csd_space_decoder.sv ***
// Chip-select space decoder with AXI4-Lite register access
//
// Notes on behaviour
// - Base field gives upper 16 start-address bits of each space.
// - Spaces 0,1 mask A29-A14 per bit; A31, A30 always compared.
// - Spaces 2,3 mask A30-A15 per bit; A31 always compared.
// - No select asserts in the excluded range, whatever the programming.
// - After reset only space 2 and the default space are enabled; space 2 covers all 4 GB; the code leaves out the excluded range.
// - Overlap picks lowest space number; default external space last.
// - Each space and default space has own control settings.
// - Waveform code 00 only; the code stores and outputs any written code. Width bit 0 is 16-bit, 1 is 8-bit.
// - Wait codes 0-7 give that many waits; 1111 one plus external.
// - Mask bit 1 drops the address bit from comparison.
// - Read recovery code 00 two, 01 one, 10 no dummy cycles.
`timescale 1ns/10ps
`default_nettype none
module csd_space_decoder (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // AXI4-Lite write address and data
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Processor access request
   input wire logic acc_valid_i,
   input wire logic acc_read_i,
   input wire logic [31:0] acc_addr_i,
   input wire logic ext_wait_i,
   output logic acc_ready_o,
   output logic acc_done_o,
   output logic acc_recover_o,
   // External memory strobes and settings
   output logic [3:0] select_output_n_o,
   output logic default_external_space_o,
   output logic acc_width8_o,
   output logic [1:0] acc_waveform_o
);
   // Register storage
   logic [31:0] bm_q [4];
   logic [31:0] ctl_q [3];
   logic cover_all_q;

   // Write channel state
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   // Read channel state
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;

   // Access outputs
   logic [3:0] cs_q;
   logic ex_q;
   logic width8_q;
   logic [1:0] wave_q;

   // Per-space fields, index 4 is the default space
   logic en [5];
   logic width8 [5];
   logic [1:0] wave [5];
   logic [3:0] wait_code [5];
   logic [1:0] rec [5];

   // Decode results
   logic [3:0] wr_bm_sel;
   logic [2:0] wr_ctl_sel;
   logic wr_hit;
   logic [31:0] rd_val;
   logic rd_hit;
   logic [3:0] hit;
   logic [3:0] grant;
   logic excl;
   logic ex_hit;
   logic [2:0] sel_idx;
   logic aw_fire;
   logic w_fire;
   logic wr_go;
   logic ar_fire;
   logic acc_go;

   csd_tmr_if tif ();

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Channel handshakes; one write and one read in flight
   assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
   assign s_axi_wready_o = !w_hold_q && !bvalid_q;
   assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
   assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
   assign wr_go = aw_hold_q && w_hold_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = !rvalid_q;
   assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;

   // Address and data are caught in either order
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 32'h0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end else begin
         if (aw_fire) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (w_fire) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   // Write response once both halves are in
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= csd_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // Write address decode
   always_comb begin
      wr_bm_sel = 4'h0;
      wr_ctl_sel = 3'h0;
      if (aw_addr_q == csd_pkg::ADDR_BM[0]) begin
         wr_bm_sel[0] = 1'b1;
      end else if (aw_addr_q == csd_pkg::ADDR_BM[1]) begin
         wr_bm_sel[1] = 1'b1;
      end else if (aw_addr_q == csd_pkg::ADDR_BM[2]) begin
         wr_bm_sel[2] = 1'b1;
      end else if (aw_addr_q == csd_pkg::ADDR_BM[3]) begin
         wr_bm_sel[3] = 1'b1;
      end else if (aw_addr_q == csd_pkg::ADDR_CTL[0]) begin
         wr_ctl_sel[0] = 1'b1;
      end else if (aw_addr_q == csd_pkg::ADDR_CTL[1]) begin
         wr_ctl_sel[1] = 1'b1;
      end else if (aw_addr_q == csd_pkg::ADDR_CTL[2]) begin
         wr_ctl_sel[2] = 1'b1;
      end
   end
   // Status word is read-only, so a write there is refused
   assign wr_hit = (wr_bm_sel != 4'h0) || (wr_ctl_sel != 3'h0);

   // Register writes and field extraction per space
   for (genvar s = 0; s < 4; s++) begin : g_space
      always_ff @(posedge sys_clk_i) begin
         if (rst_i) begin
            bm_q[s] <= csd_pkg::BM_RST;
         end else if (wr_go && wr_bm_sel[s]) begin
            bm_q[s] <= merge(bm_q[s], w_data_q, w_strb_q);
         end
      end
      localparam int R = s / 2;
      localparam int O = (s % 2) * csd_pkg::HALF;
      assign en[s] = ctl_q[R][O + csd_pkg::EN_BIT];
      assign width8[s] = ctl_q[R][O + csd_pkg::WIDTH_BIT];
      assign wave[s] = ctl_q[R][O + csd_pkg::WAVE_LSB +: 2];
      assign wait_code[s] = ctl_q[R][O + csd_pkg::WAIT_LSB +: 4];
      assign rec[s] = ctl_q[R][O + csd_pkg::REC_LSB +: 2];
   end

   // Control registers; the reserved bits stay zero
   for (genvar c = 0; c < 3; c++) begin : g_ctl
      always_ff @(posedge sys_clk_i) begin
         if (rst_i) begin
            ctl_q[c] <= csd_pkg::CTL_RST[c];
         end else if (wr_go && wr_ctl_sel[c]) begin
            ctl_q[c] <= merge(ctl_q[c], w_data_q, w_strb_q)
                        & csd_pkg::CTL_WMASK;
         end
      end
   end

   // Default space settings sit in the low half of its register
   assign en[4] = ctl_q[2][csd_pkg::EN_BIT];
   assign width8[4] = ctl_q[2][csd_pkg::WIDTH_BIT];
   assign wave[4] = ctl_q[2][csd_pkg::WAVE_LSB +: 2];
   assign wait_code[4] = ctl_q[2][csd_pkg::WAIT_LSB +: 4];
   assign rec[4] = ctl_q[2][csd_pkg::REC_LSB +: 2];

   // Space 2 spans everything outside the excluded range until software first writes its base/mask
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cover_all_q <= 1'b1;
      end else if (wr_go && wr_bm_sel[2]) begin
         cover_all_q <= 1'b0;
      end
   end

   // Read decode
   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      if (s_axi_araddr_i == csd_pkg::ADDR_BM[0]) begin
         rd_val = bm_q[0];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_BM[1]) begin
         rd_val = bm_q[1];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_BM[2]) begin
         rd_val = bm_q[2];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_BM[3]) begin
         rd_val = bm_q[3];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_CTL[0]) begin
         rd_val = ctl_q[0];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_CTL[1]) begin
         rd_val = ctl_q[1];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_CTL[2]) begin
         rd_val = ctl_q[2];
      end else if (s_axi_araddr_i == csd_pkg::ADDR_STAT) begin
         rd_val = {25'h0, acc_recover_o, tif.active, ex_q, cs_q};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read data is held until the master takes it
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= csd_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_val;
         rresp_q <= rd_hit ? csd_pkg::RESP_OKAY : csd_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // Excluded range wraps through zero as printed
   assign excl = (acc_addr_i >= csd_pkg::EXCL_LO)
                 || (acc_addr_i <= csd_pkg::EXCL_HI);

   // Base compare over A31-A14; base bits A15, A14 compare as zero
   for (genvar s = 0; s < 4; s++) begin : g_match
      logic [17:0] care;
      logic match;
      if (s < 2) begin : g_lo
         assign care = {2'b11, ~bm_q[s][15:0]};
      end else begin : g_hi
         assign care = {1'b1, ~bm_q[s][15:0], 1'b0};
      end
      assign match = ((acc_addr_i[31:14]
                      ^ {bm_q[s][31:csd_pkg::BASE_LSB], 2'b00})
                      & care) == 18'h0;
      if (s == 2) begin : g_all
         assign hit[s] = en[s] && !excl && (match || cover_all_q);
      end else begin : g_one
         assign hit[s] = en[s] && !excl && match;
      end
   end

   // Lowest-numbered hit wins, default space only when none hits
   assign grant = hit & (~hit + 4'h1);
   assign ex_hit = (hit == 4'h0) && en[4] && !excl;

   // Settings come from the winning space
   assign sel_idx = grant[0] ? 3'd0 : grant[1] ? 3'd1 : grant[2] ? 3'd2
                  : grant[3] ? 3'd3 : 3'd4;

   // Timer start and settings handed over
   assign acc_ready_o = !tif.active;
   assign acc_go = acc_valid_i && !tif.active;
   assign tif.start = acc_go;
   assign tif.is_read = acc_read_i;
   assign tif.wait_code = wait_code[sel_idx];
   assign tif.rec_code = rec[sel_idx];
   assign tif.ext_wait = ext_wait_i;

   csd_cycle_timer u_timer (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .tif(tif)
   );

   // Strobes held from the cycle after start through the done cycle, off in recovery
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cs_q <= 4'h0;
         ex_q <= 1'b0;
         width8_q <= 1'b0;
         wave_q <= 2'h0;
      end else if (acc_go) begin
         cs_q <= grant;
         ex_q <= ex_hit;
         width8_q <= width8[sel_idx];
         wave_q <= wave[sel_idx];
      end else if (tif.done) begin
         cs_q <= 4'h0;
         ex_q <= 1'b0;
      end
   end

   // Outputs
   assign select_output_n_o = ~cs_q;
   assign default_external_space_o = ex_q;
   assign acc_width8_o = width8_q;
   assign acc_waveform_o = wave_q;
   assign acc_done_o = tif.done;
   assign acc_recover_o = tif.recover;
endmodule
`default_nettype wire

// *** csd_space_decoder_assertions.sv ***
// Port checker for the chip-select space decoder
`timescale 1ns/10ps
`default_nettype none
module csd_space_decoder_assertions (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic acc_valid_i,
   input wire logic [31:0] acc_addr_i,
   input wire logic acc_ready_o,
   input wire logic acc_done_o,
   input wire logic acc_recover_o,
   input wire logic [3:0] select_output_n_o,
   input wire logic default_external_space_o,
   input wire logic acc_width8_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Reset layout is trusted only until software writes anything
   logic wr_seen_q;
   wire take = acc_valid_i && acc_ready_o;
   wire excl = acc_addr_i >= 32'hffff8000 || acc_addr_i <= 32'h1fffbfff;
   wire quiet = &select_output_n_o;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) wr_seen_q <= 1'b0;
      else if (s_axi_wvalid_i && s_axi_wready_o) wr_seen_q <= 1'b1;
   end
   // Select relations
   property p_one_space; $onehot0(~select_output_n_o); endproperty
   property p_no_clash; !(default_external_space_o && !quiet); endproperty
   property p_excluded; take && excl |=> quiet && !default_external_space_o; endproperty
   property p_reset_spaces;
      take && !wr_seen_q |=> select_output_n_o[0] && select_output_n_o[1] && select_output_n_o[3];
   endproperty
   property p_idle_quiet; acc_ready_o |-> quiet; endproperty
   property p_done_pulse; acc_done_o |=> !acc_done_o && quiet; endproperty
   property p_rec_quiet; acc_recover_o |-> quiet && !acc_ready_o; endproperty
   property p_rec_max; acc_recover_o [*2] |=> !acc_recover_o; endproperty
   property p_width_hold; acc_recover_o |-> $stable(acc_width8_o); endproperty
   a_one_space: assert property (p_one_space) else $error("two selects low");
   a_no_clash: assert property (p_no_clash) else $error("select with default");
   a_excluded: assert property (p_excluded) else $error("select in excluded range");
   a_reset_spaces: assert property (p_reset_spaces) else $error("disabled space hit");
   a_idle_quiet: assert property (p_idle_quiet) else $error("select while idle");
   a_done_pulse: assert property (p_done_pulse) else $error("strobe past done");
   a_rec_quiet: assert property (p_rec_quiet) else $error("select in recovery");
   a_rec_max: assert property (p_rec_max) else $error("recovery too long");
   a_width_hold: assert property (p_width_hold) else $error("width moved");
   // Main scenarios
   c_space0: cover property (!select_output_n_o[0]);
   c_rec_two: cover property (acc_recover_o [*2]);
   c_default: cover property (default_external_space_o && acc_done_o);
endmodule
bind csd_space_decoder csd_space_decoder_assertions u_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i),
   .acc_ready_o(acc_ready_o), .acc_done_o(acc_done_o), .acc_recover_o(acc_recover_o),
   .select_output_n_o(select_output_n_o), .acc_width8_o(acc_width8_o),
   .default_external_space_o(default_external_space_o)
);
`default_nettype wire

// *** csd_tmr_if.sv ***
// Link between the decoder and its access-cycle timer
`timescale 1ns/10ps
`default_nettype none
interface csd_tmr_if;
   logic start;
   logic is_read;
   logic [3:0] wait_code;
   logic [1:0] rec_code;
   logic ext_wait;
   logic active;
   logic done;
   logic recover;
   modport ctl (output start, is_read, wait_code, rec_code, ext_wait,
                input active, done, recover);
   modport tmr (input start, is_read, wait_code, rec_code, ext_wait,
                output active, done, recover);
endinterface
`default_nettype wire

// *** tb_chip_select_space_decoder.sv ***
// Self-checking bench for the chip-select space decoder
`timescale 1ns/10ps
`default_nettype none
module tb_chip_select_space_decoder;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, acc_addr = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic acc_valid = 1'b0, acc_read = 1'b0;
   logic [3:0] stall = 4'h0, sel_n;
   logic awready, wready, bvalid, arready, rvalid, ext_wait, ready, done, recover, dflt, w8;
   logic [1:0] bresp, rresp, wave;
   int err_total = 0, comparisons = 0, cycles = 0;
   bit [31:0] lfsr = 32'h000172b9;
   bit [31:0] sh [7];
   bit [31:0] radr [7];
   bit full2 = 1'b1;
   // 10 MHz clock
   always #50 sys_clk_i = ~sys_clk_i;
   // Hang guard, far above the run length
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end
   csd_space_decoder uut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .acc_valid_i(acc_valid),
      .acc_read_i(acc_read), .acc_addr_i(acc_addr), .ext_wait_i(ext_wait),
      .acc_ready_o(ready), .acc_done_o(done), .acc_recover_o(recover),
      .select_output_n_o(sel_n), .default_external_space_o(dflt),
      .acc_width8_o(w8), .acc_waveform_o(wave)
   );
   csd_mem_model u_mem (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .select_output_n_i(sel_n),
      .stall_i(stall), .ext_wait_o(ext_wait));
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic bit [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic int ridx(input logic [31:0] a);
      for (int i = 0; i < 7; i++)
         if (a == radr[i]) return i;
      return -1;
   endfunction
   // Reference decode: 0-3 space, 4 default, 5 nothing
   function automatic int exp_sel(input bit [31:0] a);
      bit [31:0] care;
      if (a >= 32'hffff8000 || a <= 32'h1fffbfff) return 5;
      for (int i = 0; i < 4; i++) begin
         care = i < 2 ? 32'hffffc000 & ~(32'(sh[i][15:0]) << 14)
                      : 32'hffff8000 & ~(32'(sh[i][15:0]) << 15);
         if (sh[4 + i / 2][16 * (i % 2) + 11] &&
             ((i == 2 && full2) || ((a ^ {sh[i][31:16], 16'h0}) & care) == 0))
            return i;
      end
      return sh[6][11] ? 4 : 5;
   endfunction
   // Register write; address and data offered together
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int i;
      logic [1:0] resp;
      bit aw_go, w_go, b_go;
      i = ridx(a);
      @(posedge sys_clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge sys_clk_i);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = bvalid;
         resp = bresp;
         @(posedge sys_clk_i);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
      end while (!b_go);
      bready <= 1'b0;
      check(resp, i < 0 ? csd_pkg::RESP_SLVERR : csd_pkg::RESP_OKAY);
      if (i >= 0) sh[i] = i < 4 ? d : d & csd_pkg::CTL_WMASK;
      if (i == 2) full2 = 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      int i;
      logic [31:0] d;
      logic [1:0] resp;
      bit ar_go, r_go;
      i = ridx(a);
      @(posedge sys_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge sys_clk_i);
         ar_go = arvalid && arready;
         r_go = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge sys_clk_i);
         if (ar_go) arvalid <= 1'b0;
      end while (!r_go);
      rready <= 1'b0;
      check(resp, i < 0 && a != csd_pkg::ADDR_STAT ? csd_pkg::RESP_SLVERR : csd_pkg::RESP_OKAY);
      if (i >= 0) check(d, sh[i]);
      else check(d, 32'h0);
   endtask
   // One processor access, watched until the sequencer is idle again
   task automatic access(input bit [31:0] a, input bit is_rd);
      int e, n, k, d, r;
      logic [3:0] seen;
      logic dseen;
      bit [15:0] h;
      e = exp_sel(a);
      h = e < 4 ? sh[4 + e / 2][16 * (e % 2) +: 16] : sh[6][15:0];
      n = h[3:0] < 8 ? h[3:0] + 1 : h[3:0] == 15 ? 2 + (e < 4 ? stall : 0) : 1;
      seen = 4'h0;
      dseen = 1'b0;
      d = 0;
      r = 0;
      k = 0;
      @(posedge sys_clk_i);
      acc_addr <= a;
      acc_read <= is_rd;
      acc_valid <= 1'b1;
      do @(negedge sys_clk_i); while (!ready);
      @(posedge sys_clk_i);
      acc_valid <= 1'b0;
      do begin
         @(negedge sys_clk_i);
         k++;
         seen |= ~sel_n;
         dseen |= dflt;
         if (recover) r++;
         if (done && e < 5) begin
            d = k;
            check({w8, wave}, {h[4], h[7:6]});
         end
      end while (!ready);
      check(seen, e < 4 ? 32'h1 << e : 32'h0);
      check(dseen, e == 4);
      if (e < 5) begin
         check(d, n);
         check(r, is_rd && h[9:8] < 2 ? 2 - h[9:8] : 0);
      end
   endtask
   initial begin
      bit [31:0] a;
      bit [15:0] h;
      for (int i = 0; i < 4; i++) begin
         sh[i] = csd_pkg::BM_RST;
         radr[i] = csd_pkg::ADDR_BM[i];
      end
      for (int i = 0; i < 3; i++) begin
         sh[4 + i] = csd_pkg::CTL_RST[i];
         radr[4 + i] = csd_pkg::ADDR_CTL[i];
      end
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // Reset values, status and an unmapped place
      for (int i = 0; i < 7; i++) rd(radr[i]);
      rd(csd_pkg::ADDR_STAT);
      rd(32'hffffe4a0);
      // Reset layout: only space 2 answers; the default never does
      access(32'h00001000, 1'b1);
      repeat (12) begin
         a = rnd();
         access(a, a[5]);
      end
      // Refused writes and reserved control bits
      wr(csd_pkg::ADDR_STAT, 32'hffffffff);
      wr(32'hffffe4a0, 32'h1);
      wr(csd_pkg::ADDR_CTL[2], 32'hffff3f3f);
      rd(csd_pkg::ADDR_CTL[2]);
      // Overlapping spaces at 0xc000_0000, then spaces 2 and 3
      wr(csd_pkg::ADDR_BM[0], 32'hc0000003);
      wr(csd_pkg::ADDR_BM[1], 32'hc000000f);
      wr(csd_pkg::ADDR_BM[2], 32'h4000000f);
      wr(csd_pkg::ADDR_BM[3], 32'h80000001);
      wr(csd_pkg::ADDR_CTL[1], 32'h09130801);
      // Wait codes 0-7 and 15, recovery codes 0-2 and both widths on spaces 0 and 1
      for (int w = 0; w < 9; w++) begin
         stall <= 4'(w % 3);
         h = 16'h0800 | 16'((w % 3) << 8 | (w & 1) << 4 | (w < 8 ? w : 15));
         wr(csd_pkg::ADDR_CTL[0], {h ^ 16'h0010, h});
         a = rnd();
         access({16'hc000, a[15:0]}, w[0]);
         access({16'hc003, a[31:16]}, !w[0]);
         access({16'h4007, a[15:0]}, w[1]);
         access({16'h8000, a[31:16]}, !w[1]);
      end
      // Unmasked bits that differ fall to the default space
      access(32'h40080000, 1'b1);
      access(32'hc0040000, 1'b0);
      repeat (20) begin
         a = rnd();
         access(a, a[7]);
      end
      // Spaces 2, 3 and the default switched off
      wr(csd_pkg::ADDR_CTL[1], 32'h0);
      wr(csd_pkg::ADDR_CTL[2], 32'h0);
      access(32'h40070000, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
